// ### src/hspu_defs.svh
// Constants for the host serial port block
`ifndef HSPU_DEFS_SVH
`define HSPU_DEFS_SVH
`define HSPU_RXBUF_DEPTH  7'd109
`define HSPU_CTS_RESUME   7'd14
`define HSPU_FT_MIN       7'd7
`define HSPU_FT_MAX       7'd102
`define HSPU_TXBUF_AW     7
`define HSPU_TXBUF_DEPTH  8'h80
`define HSPU_SPI_FILLER   8'h00
`define HSPU_STRAP_WAIT   2'h3
`define HSPU_API_SPI_MODE 2'h1
`endif

// ### src/hspu_pkg.sv
// Types for the host serial port block
package hspu_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} hspu_rf_beat_t;
	typedef struct packed {
		logic       cts_en;
		logic       rts_en;
		logic [6:0] ft;
		logic [1:0] api;
	} hspu_cfg_t;
	typedef enum logic [1:0] {
		HSPU_IDLE,
		HSPU_START,
		HSPU_DATA,
		HSPU_STOP
	} hspu_ser_t;
endpackage

// ### src/hspu_fifo2.sv
// Two-entry skid buffer with valid/ready on both sides
`timescale 1ns/1ps
module hspu_fifo2 #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         arst_n,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] e0_q, e0_d, e1_q, e1_d;
	logic [1:0]   cnt_q, cnt_d;
	logic         push, pop;

	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = e0_q;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		e0_d  = e0_q;
		e1_d  = e1_q;
		cnt_d = cnt_q;
		if (pop) begin
			e0_d = e1_q;
		end
		if (push) begin
			if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
				e0_d = in_data;
			end else begin
				e1_d = in_data;
			end
		end
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			e0_q  <= '0;
			e1_q  <= '0;
			cnt_q <= 2'h0;
		end else begin
			e0_q  <= e0_d;
			e1_q  <= e1_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

// ### src/hspu_top.sv
// Host serial port: UART or SPI slave with receive and transmit buffers
// Functional notes
// - Only one port active, enabled and used
// - UART always on; SPI needs all pins
// - Through-hole: DOUT low at reset forces SPI
// - SPI active after select low, until reset
// - Received bytes buffered; overflow discards new byte
// - RF data to transmit buffer; drop when it and the system buffers are full
// - UART frame: start, 8 bits LSB first, stop
// - CTS high when fill reaches threshold
// - CTS low again 14 bytes below threshold
// - Receive buffer holds 109 bytes
// - RTS high withholds UART transmit data
// - Packet not fitting is discarded whole
// - Up to five characters after RTS high
// - SPI is slave only, master clocked
// - Communication only while select low
// - Attention low while data queued
// - SPI mode 0, MSB first
// - SPI always API mode 1
// - SPI full duplex, byte for byte
`timescale 1ns/1ps
`include "hspu_defs.svh"
module hspu_top import hspu_pkg::*; (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          arst_n,
	// Settings
	input  wire logic          pin_function_setting_a,
	input  wire logic          pin_function_setting_b,
	input  wire logic          pin_function_setting_c,
	input  wire logic          pin_function_setting_d,
	input  wire logic          through_hole_variant,
	input  wire hspu_cfg_t     cfg,
	input  wire logic [15:0]   baud_div_setting,
	// UART pins
	input  wire logic          uart_din,
	input  wire logic          uart_dout_i,
	output logic               uart_dout_o,
	output logic               uart_dout_oe,
	output logic               cts_n,
	input  wire logic          rts_n,
	// SPI pins
	input  wire logic          spi_sclk,
	input  wire logic          spi_ssel_n,
	input  wire logic          spi_mosi,
	output logic               spi_miso,
	output logic               slave_attention_out_n,
	// RF packet input
	input  wire hspu_rf_beat_t rf_beat,
	input  wire logic          rf_valid,
	output logic               rf_ready,
	input  wire logic          sys_buf_full,
	output logic               rf_drop,
	// Received serial data out
	output logic [7:0]         rx_data,
	output logic               rx_valid,
	input  wire logic          rx_ready,
	output logic               rx_drop,
	// Status
	output logic               spi_active,
	output logic [1:0]         api_mode
);
	// Synchronisers: din, rts, sclk, ssel, mosi, dout
	logic [5:0] s1_q, s2_q;
	logic       din_s, rts_s, sclk_s, ssel_s, mosi_s, dout_s;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= 6'h3f;
			s2_q <= 6'h3f;
		end else begin
			s1_q <= {uart_dout_i, spi_mosi, spi_ssel_n, spi_sclk, rts_n, uart_din};
			s2_q <= s1_q;
		end
	end
	assign {dout_s, mosi_s, ssel_s, sclk_s, rts_s, din_s} = s2_q;

	// Port selection and strap capture
	logic [1:0] strap_cnt_q, strap_cnt_d;
	logic       strap_q, strap_d, act_q, act_d, spi_en, sclk_p_q;
	always_comb begin
		strap_cnt_d = strap_cnt_q;
		strap_d     = strap_q;
		// Strap read only after the synchroniser has settled
		if (strap_cnt_q != `HSPU_STRAP_WAIT) begin
			strap_cnt_d = strap_cnt_q + 2'h1;
			if (strap_cnt_q == `HSPU_STRAP_WAIT - 2'h1) begin
				strap_d = through_hole_variant & ~dout_s;
			end
		end
		spi_en = (pin_function_setting_a & pin_function_setting_b &
		          pin_function_setting_c & pin_function_setting_d) | strap_q;
		act_d  = act_q | (spi_en & ~ssel_s);
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_cnt_q <= 2'h0;
			strap_q     <= 1'b0;
			act_q       <= 1'b0;
			sclk_p_q    <= 1'b0;
		end else begin
			strap_cnt_q <= strap_cnt_d;
			strap_q     <= strap_d;
			act_q       <= act_d;
			sclk_p_q    <= sclk_s;
		end
	end
	assign spi_active   = act_q;
	assign api_mode     = act_q ? `HSPU_API_SPI_MODE : cfg.api;
	assign uart_dout_oe = (strap_cnt_q == `HSPU_STRAP_WAIT) & ~act_q;

	// Transmit buffer with packet commit and rewind
	logic [7:0] txmem [0:(1<<`HSPU_TXBUF_AW)-1];
	logic [`HSPU_TXBUF_AW:0] wr_q, wr_d, wc_q, wc_d, rd_q, rd_d;
	logic       tx_full, drop_q, drop_d, f_in_v, f_in_r, f_out_v, f_out_r, wr_en;
	logic [7:0] f_out;
	assign tx_full  = ((wr_q - rd_q) == `HSPU_TXBUF_DEPTH);
	// System buffers absorb a stall; both full means the packet is lost
	assign rf_ready = ~tx_full | sys_buf_full | drop_q;
	assign f_in_v   = (rd_q != wc_q);
	always_comb begin
		wr_d    = wr_q;
		wc_d    = wc_q;
		rd_d    = rd_q;
		drop_d  = drop_q;
		wr_en   = 1'b0;
		rf_drop = 1'b0;
		if (rf_valid & rf_ready) begin
			if (drop_q | tx_full) begin
				wr_d    = wc_q;
				drop_d  = ~rf_beat.last;
				rf_drop = rf_beat.last;
			end else begin
				wr_en = 1'b1;
				wr_d  = wr_q + 1'b1;
				if (rf_beat.last) begin
					wc_d = wr_q + 1'b1;
				end
			end
		end
		if (f_in_v & f_in_r) begin
			rd_d = rd_q + 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (wr_en) begin
			txmem[wr_q[`HSPU_TXBUF_AW-1:0]] <= rf_beat.data;
		end
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_q   <= '0;
			wc_q   <= '0;
			rd_q   <= '0;
			drop_q <= 1'b0;
		end else begin
			wr_q   <= wr_d;
			wc_q   <= wc_d;
			rd_q   <= rd_d;
			drop_q <= drop_d;
		end
	end

	hspu_fifo2 #(.W(8)) u_skid (
		.clock     (clock),
		.arst_n    (arst_n),
		.in_valid  (f_in_v),
		.in_ready  (f_in_r),
		.in_data   (txmem[rd_q[`HSPU_TXBUF_AW-1:0]]),
		.out_valid (f_out_v),
		.out_ready (f_out_r),
		.out_data  (f_out)
	);

	// UART receiver and transmitter
	hspu_ser_t  ur_st_q, ur_st_d, ut_st_q, ut_st_d;
	logic [15:0] ur_cnt_q, ur_cnt_d, ut_cnt_q, ut_cnt_d;
	logic [2:0] ur_bit_q, ur_bit_d, ut_bit_q, ut_bit_d;
	logic [7:0] ur_sh_q, ur_sh_d, ut_sh_q, ut_sh_d;
	logic       ur_push, ut_take, ut_line_q, ut_line_d;
	// Stops only at character boundaries, well inside the five allowed
	assign ut_take = (ut_st_q == HSPU_IDLE) & ~act_q & f_out_v &
	                 ~(cfg.rts_en & rts_s);
	always_comb begin
		ur_st_d  = ur_st_q;
		ur_cnt_d = (ur_cnt_q == 16'h0) ? baud_div_setting : ur_cnt_q - 16'h1;
		ur_bit_d = ur_bit_q;
		ur_sh_d  = ur_sh_q;
		ur_push  = 1'b0;
		case (ur_st_q)
			HSPU_IDLE: begin
				ur_cnt_d = {1'b0, baud_div_setting[15:1]};
				if (~din_s & ~act_q) begin
					ur_st_d = HSPU_START;
				end
			end
			HSPU_START: begin
				if (ur_cnt_q == 16'h0) begin
					ur_st_d  = din_s ? HSPU_IDLE : HSPU_DATA;
					ur_bit_d = 3'h0;
				end
			end
			HSPU_DATA: begin
				if (ur_cnt_q == 16'h0) begin
					ur_sh_d  = {din_s, ur_sh_q[7:1]};
					ur_bit_d = ur_bit_q + 3'h1;
					if (ur_bit_q == 3'h7) begin
						ur_st_d = HSPU_STOP;
					end
				end
			end
			HSPU_STOP: begin
				if (ur_cnt_q == 16'h0) begin
					ur_push = din_s;
					ur_st_d = HSPU_IDLE;
				end
			end
			default: ur_st_d = HSPU_IDLE;
		endcase
	end
	always_comb begin
		ut_st_d   = ut_st_q;
		ut_cnt_d  = (ut_cnt_q == 16'h0) ? baud_div_setting : ut_cnt_q - 16'h1;
		ut_bit_d  = ut_bit_q;
		ut_sh_d   = ut_sh_q;
		ut_line_d = ut_line_q;
		case (ut_st_q)
			HSPU_IDLE: begin
				ut_line_d = 1'b1;
				ut_cnt_d  = baud_div_setting;
				if (ut_take) begin
					ut_sh_d   = f_out;
					ut_line_d = 1'b0;
					ut_bit_d  = 3'h0;
					ut_st_d   = HSPU_START;
				end
			end
			HSPU_START, HSPU_DATA: begin
				if (ut_cnt_q == 16'h0) begin
					ut_line_d = ut_sh_q[0];
					ut_sh_d   = {1'b1, ut_sh_q[7:1]};
					if (ut_st_q == HSPU_DATA) begin
						ut_bit_d = ut_bit_q + 3'h1;
					end
					if (ut_st_q == HSPU_DATA && ut_bit_q == 3'h7) begin
						ut_line_d = 1'b1;
						ut_st_d   = HSPU_STOP;
					end else begin
						ut_st_d = HSPU_DATA;
					end
				end
			end
			HSPU_STOP: begin
				if (ut_cnt_q == 16'h0) begin
					ut_st_d = HSPU_IDLE;
				end
			end
			default: ut_st_d = HSPU_IDLE;
		endcase
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ur_st_q   <= HSPU_IDLE;
			ur_cnt_q  <= 16'h0;
			ur_bit_q  <= 3'h0;
			ur_sh_q   <= 8'h00;
			ut_st_q   <= HSPU_IDLE;
			ut_cnt_q  <= 16'h0;
			ut_bit_q  <= 3'h0;
			ut_sh_q   <= 8'h00;
			ut_line_q <= 1'b1;
		end else begin
			ur_st_q   <= ur_st_d;
			ur_cnt_q  <= ur_cnt_d;
			ur_bit_q  <= ur_bit_d;
			ur_sh_q   <= ur_sh_d;
			ut_st_q   <= ut_st_d;
			ut_cnt_q  <= ut_cnt_d;
			ut_bit_q  <= ut_bit_d;
			ut_sh_q   <= ut_sh_d;
			ut_line_q <= ut_line_d;
		end
	end
	assign uart_dout_o = ut_line_q;

	// SPI slave, mode 0; the sampled clock caps the master rate
	logic [7:0] sp_rx_q, sp_rx_d, sp_tx_q, sp_tx_d;
	logic [2:0] sp_bit_q, sp_bit_d;
	logic       sp_v_q, sp_v_d, ssel_p_q, sp_push, sp_load, rise, fall;
	assign rise    = sclk_s & ~sclk_p_q;
	assign fall    = ~sclk_s & sclk_p_q;
	assign sp_load = act_q & ~ssel_s & ((ssel_p_q & ~ssel_s) | (fall & sp_bit_q == 3'h0));
	assign f_out_r = act_q ? sp_load : ut_take;
	always_comb begin
		sp_rx_d  = sp_rx_q;
		sp_tx_d  = sp_tx_q;
		sp_bit_d = sp_bit_q;
		sp_v_d   = sp_v_q;
		sp_push  = 1'b0;
		if (ssel_s | ~act_q) begin
			sp_bit_d = 3'h0;
		end else if (rise) begin
			sp_rx_d  = {sp_rx_q[6:0], mosi_s};
			sp_bit_d = sp_bit_q + 3'h1;
			sp_push  = (sp_bit_q == 3'h7);
		end else if (sp_load) begin
			sp_tx_d = f_out_v ? f_out : `HSPU_SPI_FILLER;
			sp_v_d  = f_out_v;
		end else if (fall) begin
			sp_tx_d = {sp_tx_q[6:0], 1'b0};
			if (sp_bit_q == 3'h7) begin
				sp_v_d = 1'b0;
			end
		end
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sp_rx_q  <= 8'h00;
			sp_tx_q  <= 8'h00;
			sp_bit_q <= 3'h0;
			sp_v_q   <= 1'b0;
			ssel_p_q <= 1'b1;
		end else begin
			sp_rx_q  <= sp_rx_d;
			sp_tx_q  <= sp_tx_d;
			sp_bit_q <= sp_bit_d;
			sp_v_q   <= sp_v_d;
			// Seen high until active, so the first select also loads a byte
			ssel_p_q <= ssel_s | ~act_q;
		end
	end
	assign spi_miso = sp_tx_q[7];
	assign slave_attention_out_n = ~(act_q & (f_in_v | f_out_v | sp_v_q));

	// Serial receive buffer, CTS hysteresis
	logic [7:0] rxmem [0:108];
	logic [6:0] rwp_q, rwp_d, rrp_q, rrp_d, rcnt_q, rcnt_d, thr;
	logic [7:0] rxo_q, rxo_d;
	logic       rxv_q, rxv_d, cts_q, cts_d, push, wen, pop;
	assign push = act_q ? sp_push : ur_push;
	// Output register counts as one of the 109 places
	assign wen  = push & ((rcnt_q + {6'h0, rxv_q}) != `HSPU_RXBUF_DEPTH);
	assign pop  = (rcnt_q != 7'h0) & (~rxv_q | rx_ready);
	assign thr  = (cfg.ft < `HSPU_FT_MIN) ? `HSPU_FT_MIN :
	              (cfg.ft > `HSPU_FT_MAX) ? `HSPU_FT_MAX : cfg.ft;
	always_comb begin
		rwp_d   = wen ? ((rwp_q == `HSPU_RXBUF_DEPTH - 7'h1) ? 7'h0 : rwp_q + 7'h1) : rwp_q;
		rrp_d   = pop ? ((rrp_q == `HSPU_RXBUF_DEPTH - 7'h1) ? 7'h0 : rrp_q + 7'h1) : rrp_q;
		rcnt_d  = rcnt_q + {6'h0, wen} - {6'h0, pop};
		rx_drop = push & ~wen;
		rxo_d   = pop ? rxmem[rrp_q] : rxo_q;
		rxv_d   = pop | (rxv_q & ~rx_ready);
		cts_d   = cts_q;
		if (~cfg.cts_en) begin
			cts_d = 1'b0;
		end else if (rcnt_q >= thr) begin
			cts_d = 1'b1;
		end else if (rcnt_q + `HSPU_CTS_RESUME <= thr || rcnt_q == 7'h0) begin
			cts_d = 1'b0;
		end
	end
	always_ff @(posedge clock) begin
		if (wen) begin
			rxmem[rwp_q] <= act_q ? sp_rx_d : ur_sh_q;
		end
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rwp_q  <= 7'h0;
			rrp_q  <= 7'h0;
			rcnt_q <= 7'h0;
			rxo_q  <= 8'h00;
			rxv_q  <= 1'b0;
			cts_q  <= 1'b0;
		end else begin
			rwp_q  <= rwp_d;
			rrp_q  <= rrp_d;
			rcnt_q <= rcnt_d;
			rxo_q  <= rxo_d;
			rxv_q  <= rxv_d;
			cts_q  <= cts_d;
		end
	end
	assign rx_data  = rxo_q;
	assign rx_valid = rxv_q;
	assign cts_n    = cts_q;
endmodule

// ### test/hspu_top_assertions.sv
// Pin-level assertions for the host serial port
`timescale 1ns/1ps
module hspu_top_assertions import hspu_pkg::*; (
	// Clock, reset, settings
	input wire logic          clock,
	input wire logic          arst_n,
	input wire hspu_cfg_t     cfg,
	// Pins
	input wire logic          uart_dout_oe,
	input wire logic          cts_n,
	input wire logic          slave_attention_out_n,
	// Streams
	input wire hspu_rf_beat_t rf_beat,
	input wire logic          rf_valid,
	input wire logic          rf_ready,
	input wire logic          sys_buf_full,
	input wire logic          rf_drop,
	input wire logic [7:0]    rx_data,
	input wire logic          rx_valid,
	input wire logic          rx_ready,
	input wire logic          rx_drop,
	// Status
	input wire logic          spi_active,
	input wire logic [1:0]    api_mode
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	AST_API_MODE: assert property (api_mode == (spi_active ? 2'h1 : cfg.api))
		else $error("api mode wrong");
	AST_SPI_STICKY: assert property (spi_active |=> spi_active)
		else $error("spi port released");
	AST_ONE_PORT: assert property (spi_active && $past(spi_active) |-> !uart_dout_oe)
		else $error("uart driven while spi active");
	AST_CTS_OFF: assert property (!cfg.cts_en && !$past(cfg.cts_en) |-> !cts_n)
		else $error("cts raised while disabled");
	AST_DROP_CTS: assert property (rx_drop && cfg.cts_en |-> cts_n)
		else $error("drop with cts low");
	AST_ATTN: assert property (!slave_attention_out_n |-> spi_active)
		else $error("attention while spi idle");
	AST_RX_HOLD: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
		else $error("rx byte not held");
	AST_RF_DROP: assert property (rf_drop |-> rf_valid && rf_ready && rf_beat.last)
		else $error("drop off last beat");
	AST_RF_STALL: assert property (!rf_ready |-> !sys_buf_full)
		else $error("stall with system full");
	cover property (rf_drop);
	cover property (rx_drop);
	cover property ($rose(spi_active));
	cover property ($rose(cts_n));
endmodule

// ### test/hspu_host.sv
// Host model: UART peer and SPI master
`timescale 1ns/1ps
module hspu_host #(
	parameter int BIT_NS = 16
) (
	// UART lines
	output logic      uart_din,
	input  wire logic uart_dout,
	// SPI lines
	output logic      spi_sclk,
	output logic      spi_ssel_n,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	logic [7:0] got[$];
	// Single slave, so miso needs no external tristate here
	initial begin
		uart_din = 1'b1;
		spi_sclk = 1'b0;
		spi_ssel_n = 1'b1;
		spi_mosi = 1'b1;
	end
	task automatic uart_send(input logic [7:0] b);
		uart_din = 1'b0;
		#BIT_NS;
		for (int i = 0; i < 8; i++) begin
			uart_din = b[i];
			#BIT_NS;
		end
		uart_din = 1'b1;
		#BIT_NS;
	endtask
	task automatic spi_sel(input logic lvl);
		#125;
		spi_ssel_n = lvl;
		#125;
	endtask
	task automatic spi_byte(input logic [7:0] o, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			spi_mosi = o[i];
			#62.5 spi_sclk = 1'b1;
			r[i] = spi_miso;
			#62.5 spi_sclk = 1'b0;
		end
		// Released line shows the inverse, not a stale bit
		spi_mosi = ~o[0];
	endtask
	// Accepts every framed char, also those after a hold-off
	initial forever begin
		logic [7:0] b;
		@(negedge uart_dout);
		#(BIT_NS / 2);
		for (int i = 0; i < 8; i++) begin
			#BIT_NS;
			b[i] = uart_dout;
		end
		#BIT_NS;
		if (uart_dout)
			got.push_back(b);
	end
endmodule

// ### test/hspu_top_test.sv
// Self-checking testbench for the host serial port
`timescale 1ns/1ps
`include "hspu_defs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
	$display("MISMATCH %0t got %0h want %0h", $time, a, e); end end
`define WAIT(c) begin int k; for (k = 0; k < 30000 && !(c); k++) @(posedge clock); \
	if (!(c)) begin num_errors++; $display("MISMATCH %0t timeout", $time); conclude(); end end
module hspu_top_test import hspu_pkg::*;;
	logic          clock = 1'b0;
	logic          arst_n = 1'b0;
	logic          spi_pins = 1'b1;
	hspu_cfg_t     cfg = '{1'b0, 1'b1, 7'd7, 2'h2};
	logic [15:0]   baud_div = 16'h0001;
	logic          rts_n = 1'b0;
	logic          sys_full = 1'b0;
	hspu_rf_beat_t rf_beat = '0;
	logic          rf_valid = 1'b0;
	logic          rx_ready = 1'b1;
	logic [7:0]    b;
	logic [7:0]    rxq[$];
	wire           uart_din, uart_dout_i, uart_dout_o, uart_dout_oe, cts_n, sclk, ssel_n, mosi;
	wire           miso, attn_n, rf_ready, rf_drop, rx_valid, rx_drop, spi_active;
	wire [7:0]     rx_data;
	wire [1:0]     api_mode;
	int            num_errors = 0;
	int            n_compared = 0;
	int            drops = 0;
	int            rf_drops = 0;
	int            good;
	bit            stalled = 1'b0;
	hspu_top u_dut (.clock(clock), .arst_n(arst_n), .pin_function_setting_a(spi_pins),
		.pin_function_setting_b(spi_pins), .pin_function_setting_c(spi_pins),
		.pin_function_setting_d(spi_pins), .through_hole_variant(1'b0), .cfg(cfg),
		.baud_div_setting(baud_div), .uart_din(uart_din), .uart_dout_i(uart_dout_i),
		.uart_dout_o(uart_dout_o), .uart_dout_oe(uart_dout_oe), .cts_n(cts_n), .rts_n(rts_n),
		.spi_sclk(sclk), .spi_ssel_n(ssel_n), .spi_mosi(mosi), .spi_miso(miso),
		.slave_attention_out_n(attn_n), .rf_beat(rf_beat), .rf_valid(rf_valid),
		.rf_ready(rf_ready), .sys_buf_full(sys_full), .rf_drop(rf_drop), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_drop(rx_drop), .spi_active(spi_active),
		.api_mode(api_mode));
	hspu_host u_host (.uart_din(uart_din), .uart_dout(uart_dout_o), .spi_sclk(sclk),
		.spi_ssel_n(ssel_n), .spi_mosi(mosi), .spi_miso(miso));
	// Pull-up on DOUT whenever the device releases it
	assign uart_dout_i = uart_dout_oe ? uart_dout_o : 1'b1;
	initial forever #4 clock = ~clock;
	always @(posedge clock) begin
		if (rx_valid && rx_ready)
			rxq.push_back(rx_data);
		drops += rx_drop;
		rf_drops += rf_drop;
	end
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Leaves valid high; the caller lowers it after the last packet
	task automatic rf_send(input int n, input int base);
		for (int i = 0; i < n; i++) begin
			int w;
			rf_valid <= 1'b1;
			rf_beat <= '{8'(base + i), i == n - 1};
			for (w = 0; w < 2000; w++) begin
				@(negedge clock);
				if (rf_ready)
					break;
				if (w == 40) begin
					stalled = 1'b1;
					@(posedge clock);
					sys_full <= 1'b1;
				end
			end
			@(posedge clock);
		end
	endtask
	initial begin
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		repeat (4) @(posedge clock);
		@(negedge clock);
		`CHK(spi_active, 1'b0)
		`CHK(uart_dout_oe, 1'b1)
		`CHK(api_mode, 2'h2)
		`CHK(cts_n, 1'b0)
		u_host.uart_send(8'h1f);
		`WAIT(rxq.size() > 0)
		`CHK(rxq[0], 8'h1f)
		rxq.delete();
		$display("test uart_rx done");
		rx_ready <= 1'b0;
		cfg.cts_en <= 1'b1;
		for (int i = 0; i < 110; i++)
			u_host.uart_send(8'(i));
		repeat (20) @(posedge clock);
		`CHK(drops, 1)
		`CHK(cts_n, 1'b1)
		rx_ready <= 1'b1;
		`WAIT(rxq.size() == 109)
		repeat (20) @(posedge clock);
		`CHK(rxq.size(), 109)
		`CHK(rxq[108], 8'd108)
		`CHK(cts_n, 1'b0)
		rxq.delete();
		$display("test overflow done");
		rts_n <= 1'b1;
		repeat (4) @(posedge clock);
		for (good = 0; good < 40 && !stalled; good++)
			rf_send(4, good * 4);
		good = good - 1;
		rf_valid <= 1'b0;
		sys_full <= 1'b0;
		repeat (200) @(posedge clock);
		`CHK(rf_drops, 1)
		`CHK(4 * good >= `HSPU_TXBUF_DEPTH, 1'b1)
		`CHK(u_host.got.size(), 0)
		rts_n <= 1'b0;
		`WAIT(u_host.got.size() == 4 * good)
		repeat (40) @(posedge clock);
		`CHK(u_host.got.size(), 4 * good)
		for (int i = 0; i < 4 * good; i++)
			`CHK(u_host.got[i], 8'(i))
		$display("test transmit buffer done");
		rts_n <= 1'b1;
		// Hold-off must pass the synchroniser before new data lands
		repeat (4) @(posedge clock);
		rf_send(2, 8'h3c);
		rf_valid <= 1'b0;
		repeat (10) @(posedge clock);
		`CHK(attn_n, 1'b1)
		u_host.spi_sel(1'b0);
		u_host.spi_byte(8'ha5, b);
		`CHK(b, 8'h3c)
		u_host.spi_byte(8'h5a, b);
		`CHK(b, 8'h3d)
		u_host.spi_byte(8'h81, b);
		`CHK(b, `HSPU_SPI_FILLER)
		u_host.spi_sel(1'b1);
		@(negedge clock);
		`CHK(spi_active, 1'b1)
		`CHK(uart_dout_oe, 1'b0)
		`CHK(api_mode, 2'h1)
		`CHK(attn_n, 1'b1)
		`CHK(rxq.size(), 3)
		`CHK(rxq[0], 8'ha5)
		`CHK(rxq[2], 8'h81)
		rf_send(1, 8'h77);
		rf_valid <= 1'b0;
		repeat (10) @(posedge clock);
		`CHK(attn_n, 1'b0)
		u_host.uart_send(8'h11);
		repeat (20) @(posedge clock);
		`CHK(rxq.size(), 3)
		$display("test spi done");
		conclude();
	end
endmodule
bind hspu_top hspu_top_assertions u_chk (
	.clock                 (clock),
	.arst_n                (arst_n),
	.cfg                   (cfg),
	.uart_dout_oe          (uart_dout_oe),
	.cts_n                 (cts_n),
	.slave_attention_out_n (slave_attention_out_n),
	.rf_beat               (rf_beat),
	.rf_valid              (rf_valid),
	.rf_ready              (rf_ready),
	.sys_buf_full          (sys_buf_full),
	.rf_drop               (rf_drop),
	.rx_data               (rx_data),
	.rx_valid              (rx_valid),
	.rx_ready              (rx_ready),
	.rx_drop               (rx_drop),
	.spi_active            (spi_active),
	.api_mode              (api_mode)
);
